// >>> rtl/lpwc_pkg.sv
// Constants, vectors and types shared by the low-power wake controller.
package lpwc_pkg;

  // Recovery delays in crystal clock cycles.
  localparam int unsigned FULL_RECOVERY_CYC  = 4096;
  localparam int unsigned SHORT_RECOVERY_CYC = 32;
  localparam logic [11:0] FULL_TERM          = 12'(FULL_RECOVERY_CYC - 1);
  localparam logic [11:0] SHORT_TERM         = 12'(SHORT_RECOVERY_CYC - 1);
  localparam logic [11:0] CNT_RESET          = 12'h000;

  // Vector addresses, high byte of each pair.
  localparam logic [15:0] VEC_RESET    = 16'hfffe;
  localparam logic [15:0] VEC_BREAK    = 16'hfffc;
  localparam logic [15:0] VEC_IRQ      = 16'hfffa;
  localparam logic [15:0] VEC_CLKGEN   = 16'hfff8;
  localparam logic [15:0] VEC_T1_CH0   = 16'hfff6;
  localparam logic [15:0] VEC_T1_CH1   = 16'hfff4;
  localparam logic [15:0] VEC_T1_OVF   = 16'hfff2;
  localparam logic [15:0] VEC_T2_CH0   = 16'hfff0;
  localparam logic [15:0] VEC_T2_CH1   = 16'hffee;
  localparam logic [15:0] VEC_T2_OVF   = 16'hffec;
  localparam logic [15:0] VEC_SPI_RX   = 16'hffea;
  localparam logic [15:0] VEC_SPI_TX   = 16'hffe8;
  localparam logic [15:0] VEC_SER_ERR  = 16'hffe6;
  localparam logic [15:0] VEC_SER_RX   = 16'hffe4;
  localparam logic [15:0] VEC_SER_TX   = 16'hffe2;
  localparam logic [15:0] VEC_KEYPAD   = 16'hffe0;
  localparam logic [15:0] VEC_ADC      = 16'hffde;
  localparam logic [15:0] VEC_TIMEBASE = 16'hffdc;
  localparam logic [15:0] VEC_CAN_WAKE = 16'hffda;
  localparam logic [15:0] VEC_CAN_ERR  = 16'hffd8;
  localparam logic [15:0] VEC_CAN_RX   = 16'hffd6;
  localparam logic [15:0] VEC_CAN_TX   = 16'hffd4;
  localparam logic [15:0] VEC_NONE     = 16'h0000;

  typedef enum logic [1:0] {
    LPWC_RUN,
    LPWC_WAIT,
    LPWC_STOP,
    LPWC_RECOVER
  } lpwc_mode_e;

  // Enabled interrupt requests from the peripherals, one bit each.
  typedef struct packed {
    logic clkgen;
    logic t1_ch0;
    logic t1_ch1;
    logic t1_ovf;
    logic t2_ch0;
    logic t2_ch1;
    logic t2_ovf;
    logic spi_rx;
    logic spi_tx;
    logic ser_err;
    logic ser_rx;
    logic ser_tx;
    logic keypad;
    logic adc;
    logic timebase;
    logic can_wake;
    logic can_err;
    logic can_rx;
    logic can_tx;
  } lpwc_irq_s;

  // Run and register-access enables handed to the peripherals.
  typedef struct packed {
    logic can_run;
    logic can_regs;
    logic ser_run;
    logic spi_run;
    logic tb_run;
    logic tb_regs;
    logic tim_run;
  } lpwc_gate_s;

endpackage : lpwc_pkg

// >>> rtl/lpwc_wake_ctrl.sv
// Low-power mode sequencer: peripheral gating, wake vectors and stop recovery.
`timescale 1ns/1ps
module lpwc_wake_ctrl (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               wait_exec,
  input  wire logic               stop_exec,
  input  wire logic               short_stop_recovery_bit,
  input  wire logic               osc_run_in_stop_bit,
  input  wire logic               lvm_enable,
  input  wire logic               lvm_reset_enable,
  input  wire logic               lvm_trip,
  input  wire logic               reset_pin_n,
  input  wire logic               watchdog_timeout,
  input  wire logic               irq_pin_n,
  input  wire logic               keypad_pin_n,
  input  wire logic               emulation_mode,
  input  wire logic               break_req,
  input  wire lpwc_pkg::lpwc_irq_s irq_req,
  input  wire logic               can_bus_activity,
  input  wire logic               can_synced,
  input  wire logic               can_busy,
  input  wire logic               ser_busy,
  output lpwc_pkg::lpwc_mode_e    mode_r,
  output lpwc_pkg::lpwc_gate_s    gate_r,
  output logic                    cpu_clk_en_r,
  output logic                    bus_clk_en_r,
  output logic                    lvm_active_r,
  output logic                    chip_reset_r,
  output logic                    spi_reset_r,
  output logic                    can_rx_block_r,
  output logic                    can_frame_lost_r,
  output logic                    ser_char_lost_r,
  output logic [15:0]             vector_r,
  output logic                    vector_load_r
);

  lpwc_pkg::lpwc_mode_e mode_nxt;
  lpwc_pkg::lpwc_gate_s gate_nxt;
  logic [11:0]          rec_cnt_r;
  logic [11:0]          term_r;
  logic [15:0]          pend_vec_r;
  logic                 irq_pin_n_r;
  logic                 keypad_pin_n_r;
  logic                 irq_fall;
  logic                 keypad_fall;
  logic                 lvm_reset;
  logic                 reset_evt;
  logic                 wait_irq;
  logic                 stop_wake;
  logic                 tb_stop_wake;
  logic                 rec_done;

  // Highest vector address wins, matching the interrupt priority order.
  function automatic logic [15:0] lpwc_pick_vec(input lpwc_pkg::lpwc_irq_s r, input logic brk, input logic pin);
    logic [15:0] v;
    v = lpwc_pkg::VEC_NONE;
    if (brk)                v = lpwc_pkg::VEC_BREAK;
    else if (pin)           v = lpwc_pkg::VEC_IRQ;
    else if (r.clkgen)      v = lpwc_pkg::VEC_CLKGEN;
    else if (r.t1_ch0)      v = lpwc_pkg::VEC_T1_CH0;
    else if (r.t1_ch1)      v = lpwc_pkg::VEC_T1_CH1;
    else if (r.t1_ovf)      v = lpwc_pkg::VEC_T1_OVF;
    else if (r.t2_ch0)      v = lpwc_pkg::VEC_T2_CH0;
    else if (r.t2_ch1)      v = lpwc_pkg::VEC_T2_CH1;
    else if (r.t2_ovf)      v = lpwc_pkg::VEC_T2_OVF;
    else if (r.spi_rx)      v = lpwc_pkg::VEC_SPI_RX;
    else if (r.spi_tx)      v = lpwc_pkg::VEC_SPI_TX;
    else if (r.ser_err)     v = lpwc_pkg::VEC_SER_ERR;
    else if (r.ser_rx)      v = lpwc_pkg::VEC_SER_RX;
    else if (r.ser_tx)      v = lpwc_pkg::VEC_SER_TX;
    else if (r.keypad)      v = lpwc_pkg::VEC_KEYPAD;
    else if (r.adc)         v = lpwc_pkg::VEC_ADC;
    else if (r.timebase)    v = lpwc_pkg::VEC_TIMEBASE;
    else if (r.can_wake)    v = lpwc_pkg::VEC_CAN_WAKE;
    else if (r.can_err)     v = lpwc_pkg::VEC_CAN_ERR;
    else if (r.can_rx)      v = lpwc_pkg::VEC_CAN_RX;
    else if (r.can_tx)      v = lpwc_pkg::VEC_CAN_TX;
    return v;
  endfunction : lpwc_pick_vec

  // Falling edges on the interrupt pins; the previous level resets high (idle).
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_pin_n_r    <= 1'b1;
      keypad_pin_n_r <= 1'b1;
    end else begin
      irq_pin_n_r    <= irq_pin_n;
      keypad_pin_n_r <= keypad_pin_n;
    end
  end

  // Wake causes. The watchdog clock is off in stop, so it only counts outside stop.
  always_comb begin
    irq_fall     = irq_pin_n_r & ~irq_pin_n;
    keypad_fall  = keypad_pin_n_r & ~keypad_pin_n;
    lvm_reset    = lvm_enable & lvm_reset_enable & lvm_trip;
    reset_evt    = ~reset_pin_n | lvm_reset | (watchdog_timeout & (mode_r != lpwc_pkg::LPWC_STOP));
    wait_irq     = (|irq_req) | irq_fall | (break_req & emulation_mode);
    tb_stop_wake = irq_req.timebase & osc_run_in_stop_bit;
    stop_wake    = reset_evt | irq_fall | keypad_fall | tb_stop_wake | can_bus_activity;
    rec_done     = rec_cnt_r == term_r;
  end

  // Mode sequencing; a reset cause always beats an interrupt.
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      lpwc_pkg::LPWC_RUN: begin
        if (wait_exec) mode_nxt = lpwc_pkg::LPWC_WAIT;
        else if (stop_exec) mode_nxt = lpwc_pkg::LPWC_STOP;
      end
      lpwc_pkg::LPWC_WAIT: begin
        if (reset_evt | wait_irq) mode_nxt = lpwc_pkg::LPWC_RUN;
      end
      lpwc_pkg::LPWC_STOP: begin
        if (stop_wake) mode_nxt = lpwc_pkg::LPWC_RECOVER;
      end
      lpwc_pkg::LPWC_RECOVER: begin
        if (rec_done) mode_nxt = lpwc_pkg::LPWC_RUN;
      end
    endcase
  end

  // Peripheral enables follow the next mode so they line up with mode_r.
  always_comb begin
    gate_nxt.can_run  = (mode_nxt == lpwc_pkg::LPWC_RUN) | (mode_nxt == lpwc_pkg::LPWC_WAIT);
    gate_nxt.can_regs = mode_nxt == lpwc_pkg::LPWC_RUN;
    gate_nxt.ser_run  = gate_nxt.can_run;
    gate_nxt.spi_run  = gate_nxt.can_run;
    gate_nxt.tim_run  = gate_nxt.can_run;
    gate_nxt.tb_run   = gate_nxt.can_run | ((mode_nxt == lpwc_pkg::LPWC_STOP) & osc_run_in_stop_bit);
    gate_nxt.tb_regs  = mode_nxt == lpwc_pkg::LPWC_RUN;
  end

  // Mode, gating and clock enables.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r       <= lpwc_pkg::LPWC_RUN;
      gate_r       <= '1;
      cpu_clk_en_r <= 1'b1;
      bus_clk_en_r <= 1'b1;
      lvm_active_r <= 1'b0;
    end else begin
      mode_r       <= mode_nxt;
      gate_r       <= gate_nxt;
      cpu_clk_en_r <= mode_nxt == lpwc_pkg::LPWC_RUN;
      bus_clk_en_r <= gate_nxt.tb_run;
      lvm_active_r <= lvm_enable;
    end
  end

  // Recovery counter restarts at each stop exit; the terminal is caught at that moment.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rec_cnt_r <= lpwc_pkg::CNT_RESET;
      term_r    <= lpwc_pkg::FULL_TERM;
    end else if (mode_r == lpwc_pkg::LPWC_STOP) begin
      rec_cnt_r <= lpwc_pkg::CNT_RESET;
      term_r    <= short_stop_recovery_bit ? lpwc_pkg::SHORT_TERM : lpwc_pkg::FULL_TERM;
    end else if (mode_r == lpwc_pkg::LPWC_RECOVER && !rec_done) begin
      rec_cnt_r <= rec_cnt_r + 12'h001;
    end
  end

  // Vector delivery. Wait exits load at once; stop exits hold the vector until clocks return.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vector_r      <= lpwc_pkg::VEC_NONE;
      vector_load_r <= 1'b0;
      pend_vec_r    <= lpwc_pkg::VEC_NONE;
    end else begin
      vector_load_r <= 1'b0;
      if (mode_r == lpwc_pkg::LPWC_WAIT && (reset_evt | wait_irq)) begin
        vector_r      <= reset_evt ? lpwc_pkg::VEC_RESET
                                   : lpwc_pick_vec(irq_req, break_req & emulation_mode, irq_fall);
        vector_load_r <= 1'b1;
      end
      if (mode_r == lpwc_pkg::LPWC_STOP && stop_wake) begin
        if (reset_evt)          pend_vec_r <= lpwc_pkg::VEC_RESET;
        else if (irq_fall)      pend_vec_r <= lpwc_pkg::VEC_IRQ;
        else if (keypad_fall)   pend_vec_r <= lpwc_pkg::VEC_KEYPAD;
        else if (tb_stop_wake)  pend_vec_r <= lpwc_pkg::VEC_TIMEBASE;
        else                    pend_vec_r <= lpwc_pkg::VEC_CAN_WAKE;
      end
      if (mode_r == lpwc_pkg::LPWC_RECOVER && rec_done) begin
        vector_r      <= pend_vec_r;
        vector_load_r <= 1'b1;
      end
    end
  end

  // Resets, lost-transfer flags and the CAN receive block.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chip_reset_r     <= 1'b0;
      spi_reset_r      <= 1'b0;
      can_rx_block_r   <= 1'b0;
      can_frame_lost_r <= 1'b0;
      ser_char_lost_r  <= 1'b0;
    end else begin
      chip_reset_r     <= reset_evt;
      spi_reset_r      <= (mode_r == lpwc_pkg::LPWC_STOP) & reset_evt;
      can_frame_lost_r <= (mode_nxt == lpwc_pkg::LPWC_STOP) & (mode_r == lpwc_pkg::LPWC_RUN) & can_busy;
      ser_char_lost_r  <= (mode_nxt == lpwc_pkg::LPWC_STOP) & (mode_r == lpwc_pkg::LPWC_RUN) & ser_busy;
      // Data is ignored until the oscillator is back and the bus is resynchronised.
      if (mode_r == lpwc_pkg::LPWC_STOP && can_bus_activity) can_rx_block_r <= 1'b1;
      else if (mode_r == lpwc_pkg::LPWC_RUN && can_synced)   can_rx_block_r <= 1'b0;
    end
  end

  // Checks on the sequencer outputs.
  a_lvm_wait_reset: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_WAIT && lvm_enable && lvm_reset_enable && lvm_trip)
      |=> chip_reset_r && vector_r == lpwc_pkg::VEC_RESET)
    else $error("voltage reset did not end wait");
  a_can_wait_regs: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_WAIT |-> gate_r.can_run && !gate_r.can_regs && !gate_r.tb_regs)
    else $error("wait gating wrong");
  a_stop_halts: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_STOP |-> !gate_r.can_run && !gate_r.ser_run && !gate_r.spi_run && !gate_r.tim_run)
    else $error("peripheral running in stop");
  a_ser_wait_wake: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_WAIT && irq_req.ser_rx && !reset_evt && !irq_fall && !break_req && !irq_req.clkgen)
      |=> mode_r == lpwc_pkg::LPWC_RUN && vector_load_r && vector_r >= lpwc_pkg::VEC_SER_RX)
    else $error("serial wake lost");
  a_spi_stop_reset: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_STOP && reset_evt) |=> spi_reset_r ##1 !spi_reset_r)
    else $error("SPI not reset on reset exit");
  a_tb_stop_osc: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_STOP |-> gate_r.tb_run == $past(osc_run_in_stop_bit) && !gate_r.tb_regs)
    else $error("timebase gating in stop wrong");
  a_wdog_vector: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_WAIT && watchdog_timeout) |=> vector_load_r && vector_r == lpwc_pkg::VEC_RESET)
    else $error("watchdog vector wrong");
  a_rec_clk_off: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_RECOVER |-> !bus_clk_en_r && !cpu_clk_en_r)
    else $error("clocks on during recovery");
  a_rec_term: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_RECOVER && $past(mode_r) == lpwc_pkg::LPWC_STOP)
      |-> term_r == ($past(short_stop_recovery_bit) ? 12'h01f : 12'hfff) && rec_cnt_r == 12'h000)
    else $error("recovery terminal wrong");
  a_rec_release: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_RECOVER && rec_done) |=> mode_r == lpwc_pkg::LPWC_RUN && bus_clk_en_r && vector_load_r)
    else $error("recovery release late");

  // Checks on wake sources, vector choice, gating and the lost-transfer pulses.
  a_lvm_active: assert property (@(posedge core_clk) disable iff (rst)
    lvm_enable |=> lvm_active_r)
    else $error("monitor not active");
  a_lvm_stop_exit: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_STOP && lvm_reset)
      |=> chip_reset_r && mode_r == lpwc_pkg::LPWC_RECOVER)
    else $error("voltage reset did not end stop");
  a_can_lost: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_RUN && stop_exec && !wait_exec && can_busy)
      |=> mode_r == lpwc_pkg::LPWC_STOP && can_frame_lost_r)
    else $error("frame loss not flagged");
  a_ser_lost: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_RUN && stop_exec && !wait_exec && ser_busy)
      |=> mode_r == lpwc_pkg::LPWC_STOP && ser_char_lost_r)
    else $error("character loss not flagged");
  a_wait_runs: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_WAIT |-> gate_r.ser_run && gate_r.spi_run && gate_r.tim_run && !cpu_clk_en_r)
    else $error("peripheral halted in wait");
  a_tb_wait: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_WAIT |-> gate_r.tb_run && bus_clk_en_r && !gate_r.tb_regs)
    else $error("timebase gating in wait wrong");
  a_tb_stop_wake: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_STOP && osc_run_in_stop_bit && irq_req.timebase
      && !reset_evt && !irq_fall && !keypad_fall)
      |=> mode_r == lpwc_pkg::LPWC_RECOVER && pend_vec_r == lpwc_pkg::VEC_TIMEBASE)
    else $error("timebase wake lost");
  a_rec_halt: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == lpwc_pkg::LPWC_RECOVER |-> !gate_r.tim_run && !gate_r.spi_run && !gate_r.ser_run && !gate_r.can_run)
    else $error("peripheral running in recovery");
  a_stop_refuse: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_STOP && !reset_evt && !irq_fall && !keypad_fall && !can_bus_activity
      && !(irq_req.timebase && osc_run_in_stop_bit)) |=> mode_r == lpwc_pkg::LPWC_STOP)
    else $error("stop left without a wake event");
  a_keypad_stop_vec: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_STOP && keypad_fall && !reset_evt && !irq_fall)
      |=> pend_vec_r == lpwc_pkg::VEC_KEYPAD)
    else $error("keypad stop vector wrong");
  a_can_rx_set: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_STOP && can_bus_activity) |=> can_rx_block_r && mode_r == lpwc_pkg::LPWC_RECOVER)
    else $error("bus wake did not block receive");
  a_can_rx_hold: assert property (@(posedge core_clk) disable iff (rst)
    (can_rx_block_r && !(mode_r == lpwc_pkg::LPWC_RUN && can_synced)) |=> can_rx_block_r)
    else $error("receive opened before resync");
  // The step is checked every cycle, so a stuck count shows at once rather than only at release.
  a_rec_count: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_RECOVER && !rec_done)
      |=> mode_r == lpwc_pkg::LPWC_RECOVER && rec_cnt_r == $past(rec_cnt_r) + 12'h001)
    else $error("recovery count step wrong");
  a_brk_vector: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_WAIT && break_req && emulation_mode && !reset_evt)
      |=> vector_load_r && vector_r == lpwc_pkg::VEC_BREAK)
    else $error("break vector wrong");
  a_pin_vector: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_WAIT && irq_fall && !reset_evt && !(break_req && emulation_mode))
      |=> vector_load_r && vector_r == lpwc_pkg::VEC_IRQ)
    else $error("pin vector wrong");
  a_wait_irq_wake: assert property (@(posedge core_clk) disable iff (rst)
    (mode_r == lpwc_pkg::LPWC_WAIT && (|irq_req)) |=> mode_r == lpwc_pkg::LPWC_RUN && vector_load_r)
    else $error("request did not end wait");

endmodule : lpwc_wake_ctrl

// >>> test/lpwc_periph_model.sv
// Peripheral-side model that holds enabled interrupt requests toward the sequencer.
`timescale 1ns/1ps
module lpwc_periph_model (
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           raise_en,
  input  wire logic [4:0]     raise_idx,
  input  wire logic           drop_all,
  input  wire logic           vector_load_r,
  output lpwc_pkg::lpwc_irq_s irq_req
);
  logic [18:0] req_r;

  // A request stays up as a level until the core takes a vector, as a real flag would.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_r <= 19'h00000;
    end else if (drop_all || vector_load_r) begin
      req_r <= 19'h00000;
    end else if (raise_en) begin
      req_r[raise_idx] <= 1'b1;
    end
  end

  // The struct view keeps bit 0 as the lowest vector address.
  assign irq_req = lpwc_pkg::lpwc_irq_s'(req_r);
endmodule : lpwc_periph_model

// >>> test/lpwc_wake_ctrl_bench.sv
// Self-checking bench for the low-power wake sequencer.
`timescale 1ns/1ps
module lpwc_wake_ctrl_bench;
  logic core_clk = 1'b0, rst = 1'b1, wait_exec = 1'b0, stop_exec = 1'b0;
  logic short_stop_recovery_bit = 1'b0, osc_run_in_stop_bit = 1'b0, lvm_enable = 1'b1;
  logic lvm_reset_enable = 1'b1, lvm_trip = 1'b0, reset_pin_n = 1'b1, watchdog_timeout = 1'b0;
  logic irq_pin_n = 1'b1, keypad_pin_n = 1'b1, emulation_mode = 1'b0, break_req = 1'b0;
  logic can_bus_activity = 1'b0, can_synced = 1'b0, can_busy = 1'b0, ser_busy = 1'b0;
  logic raise_en = 1'b0, drop_all = 1'b0;
  logic [4:0] raise_idx = 5'h00;
  logic [15:0] rec_cnt;
  lpwc_pkg::lpwc_irq_s irq_req;
  lpwc_pkg::lpwc_mode_e mode_r;
  lpwc_pkg::lpwc_gate_s gate_r;
  logic cpu_clk_en_r, bus_clk_en_r, lvm_active_r, chip_reset_r, spi_reset_r;
  logic can_rx_block_r, can_frame_lost_r, ser_char_lost_r, vector_load_r;
  logic [15:0] vector_r;
  int error_cnt = 0;
  int n_compared = 0;
  logic [15:0] wexp [5] = '{16'hfffa, 16'hfffc, 16'hfffe, 16'hfffe, 16'hfffe};

  // A 25 ns period gives the 40 MHz crystal clock.
  always #12.5 core_clk = ~core_clk;

  lpwc_wake_ctrl dut (.core_clk(core_clk), .rst(rst), .wait_exec(wait_exec), .stop_exec(stop_exec),
    .short_stop_recovery_bit(short_stop_recovery_bit), .osc_run_in_stop_bit(osc_run_in_stop_bit),
    .lvm_enable(lvm_enable), .lvm_reset_enable(lvm_reset_enable), .lvm_trip(lvm_trip),
    .reset_pin_n(reset_pin_n), .watchdog_timeout(watchdog_timeout), .irq_pin_n(irq_pin_n),
    .keypad_pin_n(keypad_pin_n), .emulation_mode(emulation_mode), .break_req(break_req),
    .irq_req(irq_req), .can_bus_activity(can_bus_activity), .can_synced(can_synced),
    .can_busy(can_busy), .ser_busy(ser_busy), .mode_r(mode_r), .gate_r(gate_r),
    .cpu_clk_en_r(cpu_clk_en_r), .bus_clk_en_r(bus_clk_en_r), .lvm_active_r(lvm_active_r),
    .chip_reset_r(chip_reset_r), .spi_reset_r(spi_reset_r), .can_rx_block_r(can_rx_block_r),
    .can_frame_lost_r(can_frame_lost_r), .ser_char_lost_r(ser_char_lost_r),
    .vector_r(vector_r), .vector_load_r(vector_load_r));

  lpwc_periph_model periph (.core_clk(core_clk), .rst(rst), .raise_en(raise_en), .raise_idx(raise_idx),
    .drop_all(drop_all), .vector_load_r(vector_load_r), .irq_req(irq_req));

  // Four-state compare so an unknown output never passes.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // One-cycle instruction pulse; the caller checks the mode once the edge has landed.
  task automatic enter(input logic to_stop);
    stop_exec = to_stop;
    wait_exec = ~to_stop;
    tick(1);
    stop_exec = 1'b0;
    wait_exec = 1'b0;
  endtask : enter

  task automatic raise(input int idx);
    raise_en = 1'b1;
    raise_idx = 5'(idx);
    tick(1);
    raise_en = 1'b0;
  endtask : raise

  // Bounded wait for the vector load; cycles spent in recovery are counted on the way.
  task automatic await_load(input int limit, input logic [15:0] exp, input string what);
    rec_cnt = 16'h0000;
    for (int k = 0; k < limit && vector_load_r !== 1'b1; k++) begin
      if (mode_r === lpwc_pkg::LPWC_RECOVER) rec_cnt++;
      if (mode_r === lpwc_pkg::LPWC_RECOVER) chk(bus_clk_en_r | cpu_clk_en_r, 1'b0, "clocks held");
      tick(1);
    end
    chk(vector_load_r, 1'b1, {what, " load"});
    if (exp !== 16'h0000) chk(vector_r, exp, {what, " vector"});
    tick(1);
  endtask : await_load

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Recovery runs 4096 cycles once; the limit leaves ample margin over the whole sequence.
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    tick(5);
    rst = 1'b0;
    tick(1);
    chk(mode_r, lpwc_pkg::LPWC_RUN, "reset mode");
    chk(gate_r, 7'h7f, "reset gates");
    chk(lvm_active_r, 1'b1, "monitor on");
    $display("test reset done");
    // Every enabled request ends wait; its vector climbs two bytes per source.
    for (int i = 0; i < 19; i++) begin
      enter(1'b0);
      chk(mode_r, lpwc_pkg::LPWC_WAIT, "wait entry");
      chk(gate_r, 7'h5d, "wait gates");
      chk({cpu_clk_en_r, bus_clk_en_r}, 2'b01, "wait clocks");
      raise(i);
      await_load(8, 16'hffd4 + 16'(2 * i), "wait irq");
    end
    // Pin, break, watchdog, reset-pin and monitor exits from wait.
    for (int k = 0; k < 5; k++) begin
      enter(1'b0);
      irq_pin_n = (k != 0);
      {emulation_mode, break_req} = {2{k == 1}};
      watchdog_timeout = (k == 2);
      reset_pin_n = (k != 3);
      lvm_trip = (k == 4);
      tick(1);
      chk(chip_reset_r, k >= 2, "reset pulse");
      {irq_pin_n, reset_pin_n, watchdog_timeout, break_req, emulation_mode, lvm_trip} = 6'b110000;
      await_load(8, wexp[k], "wait event");
    end
    $display("test wait exits done");
    // Short then full recovery, entered with a frame and a character in flight.
    for (int s = 1; s >= 0; s--) begin
      short_stop_recovery_bit = s[0];
      {can_busy, ser_busy} = 2'b11;
      enter(1'b1);
      {can_busy, ser_busy} = 2'b00;
      chk(mode_r, lpwc_pkg::LPWC_STOP, "stop entry");
      chk({can_frame_lost_r, ser_char_lost_r}, 2'b11, "lost data");
      chk(gate_r & 7'h5f, 7'h00, "stop gates");
      chk(bus_clk_en_r, 1'b0, "stop bus clock");
      if (s == 1) irq_pin_n = 1'b0;
      else keypad_pin_n = 1'b0;
      await_load(5000, s ? 16'hfffa : 16'hffe0, "stop pin");
      chk(rec_cnt, s ? 16'd32 : 16'd4096, "recovery length");
      chk(gate_r, 7'h7f, "gates resumed");
      {irq_pin_n, keypad_pin_n} = 2'b11;
    end
    $display("test stop recovery done");
    // Without the oscillator, timebase, other requests and watchdog leave stop untouched.
    short_stop_recovery_bit = 1'b1;
    enter(1'b1);
    raise(4);
    tick(1);
    raise(11);
    watchdog_timeout = 1'b1;
    tick(1);
    watchdog_timeout = 1'b0;
    tick(8);
    chk(mode_r, lpwc_pkg::LPWC_STOP, "stop held");
    lvm_trip = 1'b1;
    tick(1);
    lvm_trip = 1'b0;
    chk({chip_reset_r, spi_reset_r}, 2'b11, "monitor reset");
    await_load(100, 16'hfffe, "monitor exit");
    osc_run_in_stop_bit = 1'b1;
    enter(1'b1);
    chk(gate_r & 7'h5f, 7'h04, "timebase runs");
    chk(bus_clk_en_r, 1'b1, "osc bus clock");
    raise(4);
    await_load(100, 16'hffdc, "timebase wake");
    $display("test timebase done");
    // Bus activity wakes; received data stays blocked until the controller resynchronises.
    enter(1'b1);
    can_bus_activity = 1'b1;
    tick(1);
    can_bus_activity = 1'b0;
    await_load(100, 16'hffda, "can wake");
    chk(can_rx_block_r, 1'b1, "rx blocked");
    can_synced = 1'b1;
    tick(2);
    chk(can_rx_block_r, 1'b0, "rx open");
    $display("test can wake done");
    print_verdict();
  end
endmodule : lpwc_wake_ctrl_bench
